// ==== iesw_pkg.sv ====
package iesw_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] IESW_FAULT_OFS = 12'h000;
   localparam logic [11:0] IESW_STATE_OFS = 12'h004;
   localparam logic [11:0] IESW_CFG_OFS = 12'h008;
   localparam logic [11:0] IESW_RECORD_OFS = 12'h00C;
   localparam logic [11:0] IESW_LIVE_OFS = 12'h010;
   localparam logic [11:0] IESW_HEADING_OFS = 12'h014;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int IESW_FLT_FRAME_BIT = 7;
   localparam int IESW_FLT_PROBE_BIT = 6;
   localparam int IESW_FLT_BEAM_BIT = 5;
   localparam int IESW_FLT_PMEM_BIT = 4;
   localparam int IESW_FLT_BUF_BIT = 3;
   localparam int IESW_FLT_SENS_BIT = 2;
   localparam int IESW_FLT_PROC_BIT = 1;
   localparam int IESW_FLT_HEAD_BIT = 0;
   localparam int IESW_ST_PWR_LSB = 6;
   localparam int IESW_ST_WAKE_LSB = 4;
   localparam int IESW_ST_ROLL_BIT = 3;
   localparam int IESW_ST_PITCH_BIT = 2;
   localparam int IESW_ST_SCALE_BIT = 1;
   localparam int IESW_ST_ORIENT_BIT = 0;
   localparam int IESW_CFG_FRAME_BIT = 0;
   localparam int IESW_CFG_ORIENT_BIT = 1;
   localparam int IESW_CFG_PWR_LSB = 2;

   // ----------------------------------------
   // reset values and constants
   // ----------------------------------------
   localparam logic [7:0] IESW_WORD_RST = 8'h00;
   localparam logic [3:0] IESW_CFG_RST = 4'h0;
   localparam logic [8:0] IESW_HEADING_FALLBACK = 9'h05A; // 90 degrees
   localparam int IESW_SHORT_OUTAGE_MS = 1000;
   localparam int IESW_CLK_KHZ = 50000;
   localparam int IESW_SHORT_OUTAGE_CYC = IESW_SHORT_OUTAGE_MS * IESW_CLK_KHZ;

   // ----------------------------------------
   // enumerations and carriers
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      IESW_PWR_HIGH = 2'h0,
      IESW_PWR_HIGH_MINUS = 2'h1,
      IESW_PWR_LOW_PLUS = 2'h2,
      IESW_PWR_LOW = 2'h3
   } iesw_power_t;

   typedef enum logic [1:0]
   {
      IESW_WAKE_BAD_POWER = 2'h0,
      IESW_WAKE_POWER_APPLIED = 2'h1,
      IESW_WAKE_BREAK = 2'h2,
      IESW_WAKE_RTC = 2'h3
   } iesw_wake_t;

   typedef enum logic [2:0]
   {
      IESW_PW_RUN = 3'b001,
      IESW_PW_BROWN = 3'b010,
      IESW_PW_SLEEP = 3'b100
   } iesw_pwr_state_t;

   typedef struct packed
   {
      logic heading_fail;
      logic probe_no_answer;
      logic beam_order_bad;
      logic pmem_error;
      logic buffer_overflow;
      logic sensor_bad;
      logic processing_bad;
   } iesw_faults_t;

   typedef struct packed
   {
      logic roll_out;
      logic pitch_out;
   } iesw_tilt_t;
endpackage

// ==== iesw_wake_tracker.sv ====
`timescale 1ns/1ps
// --------------------------------------------------
// wakeup source tracker
// --------------------------------------------------
module iesw_wake_tracker
   import iesw_pkg::*;
#(
   parameter int OUTAGE_CYC = IESW_SHORT_OUTAGE_CYC
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic supply_ok_in,
   input wire logic power_applied_in,
   input wire logic break_in,
   input wire logic rtc_alarm_in,
   input wire logic sleep_req_in,
   output logic hold_reset_out,
   output logic asleep_out,
   output iesw_wake_t wake_out
);
   localparam int CW = $clog2(OUTAGE_CYC + 1);

   iesw_pwr_state_t state_r;
   iesw_pwr_state_t state_nxt;
   iesw_wake_t wake_r;
   iesw_wake_t wake_nxt;
   logic [CW-1:0] outage_r;
   logic [CW-1:0] outage_nxt;

   // power state and wake source selection
   always_comb
   begin
      state_nxt = state_r;
      wake_nxt = wake_r;
      outage_nxt = outage_r;
      case (state_r)
         IESW_PW_RUN:
         begin
            if (!supply_ok_in)
            begin
               state_nxt = IESW_PW_BROWN;
               outage_nxt = '0;
            end
            else if (break_in)
               wake_nxt = IESW_WAKE_BREAK;
            else if (sleep_req_in)
               state_nxt = IESW_PW_SLEEP;
         end
         IESW_PW_BROWN:
         begin
            if (outage_r != CW'(OUTAGE_CYC))
               outage_nxt = outage_r + 1'b1;
            if (supply_ok_in)
            begin
               state_nxt = IESW_PW_RUN;
               // long outage or explicit power-on counts as power applied
               if (power_applied_in || outage_r == CW'(OUTAGE_CYC))
                  wake_nxt = IESW_WAKE_POWER_APPLIED;
               else
                  wake_nxt = IESW_WAKE_BAD_POWER;
            end
         end
         IESW_PW_SLEEP:
         begin
            if (!supply_ok_in)
            begin
               state_nxt = IESW_PW_BROWN;
               outage_nxt = '0;
            end
            else if (break_in)
            begin
               state_nxt = IESW_PW_RUN;
               wake_nxt = IESW_WAKE_BREAK;
            end
            else if (rtc_alarm_in)
            begin
               state_nxt = IESW_PW_RUN;
               wake_nxt = IESW_WAKE_RTC;
            end
         end
         default:
            state_nxt = IESW_PW_RUN;
      endcase
   end

   // state registers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= IESW_PW_RUN;
         wake_r <= IESW_WAKE_POWER_APPLIED;
         outage_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         wake_r <= wake_nxt;
         outage_r <= outage_nxt;
      end
   end

   assign hold_reset_out = (state_r == IESW_PW_BROWN);
   assign asleep_out = (state_r == IESW_PW_SLEEP);
   assign wake_out = wake_r;
endmodule

// ==== iesw_top.sv ====
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module iesw_top
   import iesw_pkg::*;
#(
   parameter int OUTAGE_CYC = IESW_SHORT_OUTAGE_CYC
)
(
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   // apb slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // fault detectors and sensors
   input wire iesw_pkg::iesw_faults_t FAULTS_IN,
   input wire iesw_pkg::iesw_tilt_t TILT_IN,
   input wire logic [8:0] HEADING_IN,
   input wire logic RECORD_STROBE_IN,
   // power and wakeup sources
   input wire logic SUPPLY_OK_IN,
   input wire logic POWER_APPLIED_IN,
   input wire logic COMM_BREAK_IN,
   input wire logic RTC_ALARM_IN,
   input wire logic SLEEP_REQ_IN,
   // outputs
   output logic EARTH_REFERENCED_FRAME_OUT,
   output logic [8:0] HEADING_OUT,
   output logic [7:0] MEASUREMENT_FAULT_FLAGS_OUT,
   output logic [7:0] INSTRUMENT_STATE_FLAGS_OUT,
   output logic HW_RESET_OUT,
   output logic ASLEEP_OUT
);
   import iesw_pkg::*;

   // ----------------------------------------
   // wake tracking
   // ----------------------------------------
   logic hold_reset;
   logic asleep;
   iesw_wake_t wake_src;

   iesw_wake_tracker #(.OUTAGE_CYC(OUTAGE_CYC)) u_wake
   (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RST_N_IN),
      .supply_ok_in(SUPPLY_OK_IN),
      .power_applied_in(POWER_APPLIED_IN),
      .break_in(COMM_BREAK_IN),
      .rtc_alarm_in(RTC_ALARM_IN),
      .sleep_req_in(SLEEP_REQ_IN),
      .hold_reset_out(hold_reset),
      .asleep_out(asleep),
      .wake_out(wake_src)
   );

   // ----------------------------------------
   // configuration and live words
   // ----------------------------------------
   logic [3:0] cfg_r;
   logic [7:0] fault_word_r;
   logic [7:0] state_word_r;
   logic [31:0] record_cnt_r;
   logic cfg_earth;
   iesw_power_t cfg_power;
   logic cfg_down;
   logic frame_fallback;
   logic [7:0] fault_live;
   logic [7:0] state_live;
   logic sample_now;

   assign cfg_earth = cfg_r[IESW_CFG_FRAME_BIT];
   assign cfg_down = cfg_r[IESW_CFG_ORIENT_BIT];
   assign cfg_power = iesw_power_t'(cfg_r[IESW_CFG_PWR_LSB +: 2]);
   // earth frame drops back when heading fails
   assign frame_fallback = cfg_earth && FAULTS_IN.heading_fail;

   // fault word, one flag per detector plus the frame fallback flag, live level
   always_comb
   begin
      fault_live = IESW_WORD_RST;
      fault_live[IESW_FLT_FRAME_BIT] = frame_fallback;
      fault_live[IESW_FLT_PROBE_BIT] = FAULTS_IN.probe_no_answer;
      fault_live[IESW_FLT_BEAM_BIT] = FAULTS_IN.beam_order_bad;
      fault_live[IESW_FLT_PMEM_BIT] = FAULTS_IN.pmem_error;
      fault_live[IESW_FLT_BUF_BIT] = FAULTS_IN.buffer_overflow;
      fault_live[IESW_FLT_SENS_BIT] = FAULTS_IN.sensor_bad;
      fault_live[IESW_FLT_PROC_BIT] = FAULTS_IN.processing_bad;
      fault_live[IESW_FLT_HEAD_BIT] = FAULTS_IN.heading_fail;
   end

   // status word from config, wake source and tilt
   always_comb
   begin
      state_live = IESW_WORD_RST;
      state_live[IESW_ST_PWR_LSB +: 2] = cfg_power;
      state_live[IESW_ST_WAKE_LSB +: 2] = wake_src;
      state_live[IESW_ST_ROLL_BIT] = TILT_IN.roll_out;
      state_live[IESW_ST_PITCH_BIT] = TILT_IN.pitch_out;
      state_live[IESW_ST_SCALE_BIT] = 1'b0;
      state_live[IESW_ST_ORIENT_BIT] = cfg_down;
   end

   // snapshot only on record strobe while awake
   assign sample_now = RECORD_STROBE_IN && !hold_reset && !asleep;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic apb_setup;
   logic apb_wr;
   logic apb_rd;
   logic hit_fault;
   logic hit_state;
   logic hit_cfg;
   logic hit_record;
   logic hit_live;
   logic hit_heading;
   logic hit_any;
   logic [31:0] rd_mux;
   logic [8:0] heading_nxt;

   assign apb_setup = PSEL_IN && !PENABLE_IN;
   assign apb_wr = apb_setup && PWRITE_IN;
   assign apb_rd = apb_setup && !PWRITE_IN;
   assign hit_fault = (PADDR_IN == IESW_FAULT_OFS);
   assign hit_state = (PADDR_IN == IESW_STATE_OFS);
   assign hit_cfg = (PADDR_IN == IESW_CFG_OFS);
   assign hit_record = (PADDR_IN == IESW_RECORD_OFS);
   assign hit_live = (PADDR_IN == IESW_LIVE_OFS);
   assign hit_heading = (PADDR_IN == IESW_HEADING_OFS);
   assign hit_any = hit_fault || hit_state || hit_cfg || hit_record || hit_live
                    || hit_heading;

   // read data selection
   always_comb
   begin
      if (hit_fault)
         rd_mux = {24'h000000, fault_word_r};
      else if (hit_state)
         rd_mux = {24'h000000, state_word_r};
      else if (hit_cfg)
         rd_mux = {28'h0000000, cfg_r};
      else if (hit_record)
         rd_mux = record_cnt_r;
      else if (hit_live)
         rd_mux = {16'h0000, state_live, fault_live};
      else if (hit_heading)
         rd_mux = {23'h000000, HEADING_OUT};
      else
         rd_mux = 32'h00000000;
   end

   // heading reads 90 when the heading sensor is silent
   assign heading_nxt = FAULTS_IN.heading_fail ? IESW_HEADING_FALLBACK : HEADING_IN;

   // ----------------------------------------
   // configuration register
   // ----------------------------------------
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         cfg_r <= IESW_CFG_RST;
      else if (apb_wr && hit_cfg)
         cfg_r <= PWDATA_IN[3:0];
   end

   // ----------------------------------------
   // record snapshots
   // ----------------------------------------
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         fault_word_r <= IESW_WORD_RST;
         state_word_r <= IESW_WORD_RST;
         record_cnt_r <= 32'h00000000;
      end
      else if (hold_reset)
      begin
         fault_word_r <= IESW_WORD_RST;
         state_word_r <= IESW_WORD_RST;
      end
      else if (sample_now)
      begin
         fault_word_r <= fault_live;
         state_word_r <= state_live;
         record_cnt_r <= record_cnt_r + 32'h00000001;
      end
   end

   // ----------------------------------------
   // apb response, no wait states
   // ----------------------------------------
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         PRDATA_OUT <= 32'h00000000;
         PREADY_OUT <= 1'b0;
         PSLVERR_OUT <= 1'b0;
      end
      else
      begin
         PREADY_OUT <= apb_setup;
         PSLVERR_OUT <= apb_setup && !hit_any;
         if (apb_rd)
            PRDATA_OUT <= rd_mux;
      end
   end

   // ----------------------------------------
   // registered user outputs
   // ----------------------------------------
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         EARTH_REFERENCED_FRAME_OUT <= 1'b0;
         HEADING_OUT <= 9'h000;
         MEASUREMENT_FAULT_FLAGS_OUT <= IESW_WORD_RST;
         INSTRUMENT_STATE_FLAGS_OUT <= IESW_WORD_RST;
         HW_RESET_OUT <= 1'b0;
         ASLEEP_OUT <= 1'b0;
      end
      else
      begin
         EARTH_REFERENCED_FRAME_OUT <= cfg_earth && !frame_fallback;
         HEADING_OUT <= heading_nxt;
         MEASUREMENT_FAULT_FLAGS_OUT <= fault_word_r;
         INSTRUMENT_STATE_FLAGS_OUT <= state_word_r;
         HW_RESET_OUT <= hold_reset;
         ASLEEP_OUT <= asleep;
      end
   end
endmodule

// ==== iesw_monitor.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module iesw_monitor
   import iesw_pkg::*;
#(
   parameter int OUTAGE_CYC = IESW_SHORT_OUTAGE_CYC
)
(
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic PREADY_OUT,
   input wire logic PSLVERR_OUT,
   input wire iesw_pkg::iesw_faults_t FAULTS_IN,
   input wire iesw_pkg::iesw_tilt_t TILT_IN,
   input wire logic [8:0] HEADING_IN,
   input wire logic RECORD_STROBE_IN,
   input wire logic SUPPLY_OK_IN,
   input wire logic POWER_APPLIED_IN,
   input wire logic COMM_BREAK_IN,
   input wire logic RTC_ALARM_IN,
   input wire logic SLEEP_REQ_IN,
   input wire logic EARTH_REFERENCED_FRAME_OUT,
   input wire logic [8:0] HEADING_OUT,
   input wire logic [7:0] MEASUREMENT_FAULT_FLAGS_OUT,
   input wire logic [7:0] INSTRUMENT_STATE_FLAGS_OUT,
   input wire logic HW_RESET_OUT,
   input wire logic ASLEEP_OUT
);
   // snapshot accepted, apb setup cycle
   wire taken = RECORD_STROBE_IN && SUPPLY_OK_IN && !HW_RESET_OUT && !ASLEEP_OUT;
   wire setup = PSEL_IN && !PENABLE_IN;
   wire run = SUPPLY_OK_IN && !HW_RESET_OUT;

   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   a_ready_next: assert property (setup |=> PREADY_OUT)
      else $error("ready missing after setup");
   a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("ready longer than one cycle");
   a_unmapped_err: assert property (setup && PADDR_IN > 12'h014 |=> PSLVERR_OUT)
      else $error("no error on unmapped address");
   a_fault_capture: assert property (
      taken |-> ##2 MEASUREMENT_FAULT_FLAGS_OUT[6:1] == $past(FAULTS_IN[5:0], 2))
      else $error("fault bits 6..1 wrong");
   a_head_flag: assert property (
      taken |-> ##2 MEASUREMENT_FAULT_FLAGS_OUT[0] == $past(FAULTS_IN.heading_fail, 2))
      else $error("fault bit 0 wrong");
   a_frame_flag: assert property (MEASUREMENT_FAULT_FLAGS_OUT[7] |->
      MEASUREMENT_FAULT_FLAGS_OUT[0])
      else $error("frame fault without heading fault");
   a_frame_drop: assert property (FAULTS_IN.heading_fail |=>
      !EARTH_REFERENCED_FRAME_OUT)
      else $error("earth frame kept without heading");
   a_heading_sub: assert property (run |=> HEADING_OUT ==
      ($past(FAULTS_IN.heading_fail) ? 9'h05A : $past(HEADING_IN)))
      else $error("heading output wrong");
   a_tilt_capture: assert property (
      taken |-> ##2 INSTRUMENT_STATE_FLAGS_OUT[3:2] == $past(TILT_IN, 2))
      else $error("tilt bits wrong");
   a_scale_zero: assert property (INSTRUMENT_STATE_FLAGS_OUT[1] == 1'h0)
      else $error("scaling bit set");
   a_brown_hold: assert property (!SUPPLY_OK_IN [*2] |=> HW_RESET_OUT)
      else $error("no hold on low supply");
   a_brown_exit: assert property (SUPPLY_OK_IN [*4] |-> !HW_RESET_OUT)
      else $error("hold kept after recovery");
   a_sleep_freeze: assert property ((ASLEEP_OUT && SUPPLY_OK_IN) [*4] |->
      $stable(MEASUREMENT_FAULT_FLAGS_OUT) && $stable(INSTRUMENT_STATE_FLAGS_OUT))
      else $error("words changed while asleep");

   c_taken: cover property (taken);
   c_slverr: cover property (PSLVERR_OUT);
   c_brown: cover property ($rose(HW_RESET_OUT));
   c_wake: cover property ($fell(ASLEEP_OUT));
endmodule

bind iesw_top iesw_monitor #(.OUTAGE_CYC(OUTAGE_CYC)) u_mon (.*);

// ==== instrument_error_status_words_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) chk((a), (e))
module instrument_error_status_words_tb;
   import iesw_pkg::*;
   logic clk;
   logic rst_n;
   logic psel, pen, pwr, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   iesw_faults_t faults;
   iesw_tilt_t tilt;
   logic [8:0] hd_in, hd_out;
   logic strobe, sup_ok, pwr_app, brk, rtc, slp, earth, hw_rst, asleep;
   logic [7:0] flt_w, st_w;
   logic [32:0] q[$];
   logic [3:0] cfg;
   iesw_wake_t wk;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   int recs = 0;

   iesw_top #(.OUTAGE_CYC(20)) uut (
      .REF_CLK_IN(clk), .RST_N_IN(rst_n),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .FAULTS_IN(faults), .TILT_IN(tilt), .HEADING_IN(hd_in),
      .RECORD_STROBE_IN(strobe), .SUPPLY_OK_IN(sup_ok),
      .POWER_APPLIED_IN(pwr_app), .COMM_BREAK_IN(brk),
      .RTC_ALARM_IN(rtc), .SLEEP_REQ_IN(slp),
      .EARTH_REFERENCED_FRAME_OUT(earth), .HEADING_OUT(hd_out),
      .MEASUREMENT_FAULT_FLAGS_OUT(flt_w), .INSTRUMENT_STATE_FLAGS_OUT(st_w),
      .HW_RESET_OUT(hw_rst), .ASLEEP_OUT(asleep)
   );

   // ----------------------------------------
   // clock, compare, apb master
   // ----------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   task chk(input logic [32:0] a, input logic [32:0] e);
      comparisons++;
      if (a !== e)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, a, e);
      end
   endtask

   task end_sim();
      $display("comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         q.push_back(e);
      @(posedge clk);
      pen <= 1'h1;
      do
         @(posedge clk);
      while (pready !== 1'h1);
      psel <= 1'h0;
      pen <= 1'h0;
   endtask

   // read results checked against the oldest note
   always @(posedge clk)
      if (psel && pen && pready && !pwr && q.size() > 0)
         `CHK({pslverr, prdata}, q.pop_front());

   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         end_sim();
      end
   end

   // ----------------------------------------
   // scenario tasks
   // ----------------------------------------
   task pulse(input logic [2:0] k);
      @(posedge clk);
      {brk, rtc, slp} <= k;
      @(posedge clk);
      {brk, rtc, slp} <= 3'h0;
      repeat (3) @(posedge clk);
   endtask

   task snap(input logic [6:0] f);
      logic [7:0] ef;
      logic [7:0] es;
      @(posedge clk);
      faults <= f;
      tilt <= 2'($urandom);
      hd_in <= 9'($urandom);
      strobe <= 1'h1;
      @(posedge clk);
      strobe <= 1'h0;
      recs++;
      repeat (3) @(posedge clk);
      // expected words from the bit map, not from the design
      ef = {cfg[0] & f[6], f[5:0], f[6]};
      es = {cfg[3:2], wk, tilt, 1'h0, cfg[1]};
      `CHK(flt_w, ef);
      `CHK(st_w, es);
      `CHK(hd_out, f[6] ? 9'h05A : hd_in);
      `CHK(earth, cfg[0] & !f[6]);
      apb(1'h0, IESW_FAULT_OFS, 0, {25'h0, ef});
      apb(1'h0, IESW_STATE_OFS, 0, {25'h0, es});
      // live words and heading follow the held inputs
      apb(1'h0, IESW_LIVE_OFS, 0, {17'h0, es, ef});
      apb(1'h0, IESW_HEADING_OFS, 0, {24'h0, f[6] ? 9'h05A : hd_in});
   endtask

   task outage(input int n, input logic pa, input iesw_wake_t w);
      @(posedge clk);
      sup_ok <= 1'h0;
      repeat (n) @(posedge clk);
      `CHK(hw_rst, 1'h1);
      `CHK(flt_w, 8'h00);
      sup_ok <= 1'h1;
      pwr_app <= pa;
      @(posedge clk);
      pwr_app <= 1'h0;
      repeat (4) @(posedge clk);
      `CHK(hw_rst, 1'h0);
      wk = w;
      apb(1'h1, IESW_CFG_OFS, 32'(cfg), 0);
      snap(7'($urandom));
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(99924));
      {psel, pen, pwr, strobe, pwr_app, brk, rtc, slp} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      faults = 7'h00;
      tilt = 2'h0;
      hd_in = 9'h000;
      sup_ok = 1'h1;
      rst_n = 1'h0;
      cfg = 4'h0;
      wk = IESW_WAKE_POWER_APPLIED;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      // reset values, unmapped and read-only places
      apb(1'h0, IESW_CFG_OFS, 0, 0);
      apb(1'h0, 12'h018, 0, {1'h1, 32'h0});
      apb(1'h1, IESW_FAULT_OFS, 32'hFF, 0);
      apb(1'h0, IESW_FAULT_OFS, 0, 0);
      // every power level, all faults, no faults, heading loss in earth frame
      for (int i = 0; i < 4; i++)
      begin
         cfg = {i[1:0], 2'($urandom)};
         apb(1'h1, IESW_CFG_OFS, 32'(cfg), 0);
         apb(1'h0, IESW_CFG_OFS, 0, 33'(cfg));
         snap(7'($urandom));
      end
      snap(7'h7F);
      snap(7'h00);
      cfg = 4'h1;
      apb(1'h1, IESW_CFG_OFS, 32'(cfg), 0);
      snap(7'h40);
      // sleep refuses snapshots, clock alarm wakes
      pulse(3'h1);
      `CHK(asleep, 1'h1);
      @(posedge clk);
      strobe <= 1'h1;
      @(posedge clk);
      strobe <= 1'h0;
      apb(1'h0, IESW_RECORD_OFS, 0, 33'(recs));
      pulse(3'h2);
      `CHK(asleep, 1'h0);
      wk = IESW_WAKE_RTC;
      snap(7'($urandom));
      // break in run and in sleep
      pulse(3'h4);
      wk = IESW_WAKE_BREAK;
      snap(7'($urandom));
      pulse(3'h1);
      wk = IESW_WAKE_RTC;
      pulse(3'h4);
      `CHK(asleep, 1'h0);
      wk = IESW_WAKE_BREAK;
      snap(7'($urandom));
      // short, long and power-applied outages
      outage(5, 1'h0, IESW_WAKE_BAD_POWER);
      outage(30, 1'h0, IESW_WAKE_POWER_APPLIED);
      outage(5, 1'h1, IESW_WAKE_POWER_APPLIED);
      repeat (4) @(posedge clk);
      end_sim();
   end
endmodule
